// *** design/srs_pkg.sv ***
// Package with constants and types of the supply rail sequencer
package srs_pkg;

    // ==========================================================
    // Rail indices (13 sequenced rails, always-on regulator apart)
    // ==========================================================
    localparam int NUM_RAILS = 13;
    localparam int RAIL_REG0 = 0;
    localparam int RAIL_REG1 = 1;
    localparam int RAIL_REG2 = 2;
    localparam int RAIL_REG3 = 3;
    localparam int RAIL_REG4 = 4;
    localparam int RAIL_REG5 = 5;
    localparam int RAIL_REG6 = 6;
    localparam int RAIL_REG7 = 7;
    localparam int RAIL_REG8 = 8;
    localparam int RAIL_REG9 = 9;
    localparam int RAIL_SDA = 10;
    localparam int RAIL_SDB = 11;
    localparam int RAIL_SDC = 12;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 250;
    localparam int DELAY_SHORT_US = 3750;
    localparam int DELAY_MID_US = 2500;
    localparam int DELAY_LONG_US = 15000;
    localparam int WAIT_REQ_US = 10000;
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;
    localparam int DELAY_MID_CYC = DELAY_MID_US * CLK_MHZ;
    localparam int DELAY_LONG_CYC = DELAY_LONG_US * CLK_MHZ;
    localparam int WAIT_REQ_CYC = WAIT_REQ_US * CLK_MHZ;
    localparam int CNT_W = 24;

    // ==========================================================
    // Trigger groups and delay classes
    // ==========================================================
    typedef enum logic [1:0] {
        TRIG_INTERNAL = 2'h0,
        TRIG_SDA = 2'h1,
        TRIG_SDB = 2'h2,
        TRIG_SYNC = 2'h3
    } srs_trig_type;

    typedef enum logic [1:0] {
        DLY_NONE = 2'h0,
        DLY_SHORT = 2'h1,
        DLY_MID = 2'h2,
        DLY_LONG = 2'h3
    } srs_dly_type;

    // Fixed per-rail attributes
    typedef struct packed {
        logic defaultOn;
        srs_trig_type trig;
        srs_dly_type dly;
    } srs_rail_cfg_type;

    // Top state machine phases seen by the sequencer
    typedef enum logic [2:0] {
        PH_OFF = 3'h0,
        PH_RTC = 3'h1,
        PH_SEQ = 3'h3,
        PH_NORMAL = 3'h2,
        PH_SLEEP_REQ = 3'h6,
        PH_REBOOT_REQ = 3'h7,
        PH_SLEEP = 3'h5,
        PH_REBOOT = 3'h4
    } srs_phase_type;

    // Synchronised trigger pins
    typedef struct packed {
        logic sdaEnableN;
        logic sdbEnable;
        logic syncEnable;
        logic reg4Enable;
    } srs_pins_type;

    // Per-rail fixed configuration, rail 0 first
    function automatic srs_rail_cfg_type railCfg(input int r);
        case (r)
            0: railCfg = '{1'b0, TRIG_SDB, DLY_SHORT};
            1: railCfg = '{1'b1, TRIG_SYNC, DLY_SHORT};
            2: railCfg = '{1'b1, TRIG_INTERNAL, DLY_NONE};
            3: railCfg = '{1'b0, TRIG_SDB, DLY_NONE};
            4: railCfg = '{1'b1, TRIG_INTERNAL, DLY_SHORT};
            5: railCfg = '{1'b1, TRIG_SYNC, DLY_SHORT};
            6: railCfg = '{1'b1, TRIG_SYNC, DLY_LONG};
            7: railCfg = '{1'b0, TRIG_INTERNAL, DLY_LONG};
            8: railCfg = '{1'b0, TRIG_SYNC, DLY_LONG};
            9: railCfg = '{1'b0, TRIG_SYNC, DLY_SHORT};
            10: railCfg = '{1'b1, TRIG_SDA, DLY_MID};
            11: railCfg = '{1'b1, TRIG_SDB, DLY_MID};
            default: railCfg = '{1'b0, TRIG_INTERNAL, DLY_LONG};
        endcase
    endfunction : railCfg

    // Cycle count of a delay class
    function automatic logic [23:0] dlyCycles(input srs_dly_type d);
        case (d)
            DLY_SHORT: dlyCycles = 24'(DELAY_SHORT_CYC);
            DLY_MID: dlyCycles = 24'(DELAY_MID_CYC);
            DLY_LONG: dlyCycles = 24'(DELAY_LONG_CYC);
            default: dlyCycles = 24'h00_0000;
        endcase
    endfunction : dlyCycles

endpackage : srs_pkg

// *** design/srs_supply_rail_sequencer.sv ***
// Supply rail sequencer: enables, delays, power-down and power-good
`timescale 1ns/1ps
`default_nettype none

//Contract
// (RL1) Sequence all rails on entering sequencing
// (RL2) Always-on regulator enabled from RTC state
// (RL3) Rail: default state, trigger group, delay
// (RL4) Internal trigger rises entering sequencing state
// (RL5) Stepdown A pin triggers when low
// (RL6) Stepdown B, sync pins trigger when high
// (RL7) Default-on rail turns on after delay
// (RL8) Default-off rails never sequenced on
// (RL9) No delays once normal state reached
// (RL10) Rails 0,1 share 3.75 ms delay
// (RL11) Rails 6,7,8 share 15 ms delay
// (RL12) Rails 5,9 share trigger and delay
// (RL13) Outside normal: pins and bits switch rails
// (RL14) Normal: pins only stepdowns and rail 4
// (RL15) Sequencing: bits of 2,4,A,B switch rails
// (RL16) Power-down starts at request; pins reactivate
// (RL17) Sleep or reboot 10 ms after request
// (RL18) Sleep/reboot entry turns all rails off
// (RL19) Request: deasserting pin edge turns rail off
// (RL20) Rail 4 held on if pin low early
// (RL21) Rail 4 good low when pin low
// (RL22) Good high only when on and regulating
// (RL23) Slow clock after RTC reset high, supply valid
// (RL24) Source select bit; crystal clock only out
// (RL25) Non-scaling voltage applied at write acknowledge
// (RL26) Scaling supplies ramp from programmed start time
// (RL27) Counters reload when trigger event recurs
module srs_supply_rail_sequencer
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Top state machine phase
    input wire srs_phase_type phase,
    // Trigger pins from host (asynchronous)
    input wire logic stepdown_a_enable_pin,
    input wire logic stepdown_b_enable_pin,
    input wire logic sync_group_enable_pin,
    input wire logic reg4_enable_pin,
    // Enable bits from registers, one per rail
    input wire logic [NUM_RAILS-1:0] railEnableBits,
    // Regulation status from analog, one per rail
    input wire logic [NUM_RAILS-1:0] railInRegulation,
    // Voltage code write and acknowledge
    input wire logic [7:0] voltCode,
    input wire logic [NUM_RAILS-1:0] voltWriteAck,
    input wire logic [NUM_RAILS-1:0] scalingRail,
    input wire logic scalingStart,
    // Slow clock sources and conditions
    input wire logic slowSourceXtal,
    input wire logic xtalClockEnable,
    input wire logic rtc_reset_output,
    input wire logic slow_clock_domain_supply,
    // Rail controls
    output logic [NUM_RAILS-1:0] railOn,
    output logic rtcRegOn,
    output logic stepdown_a_power_good,
    output logic stepdown_b_power_good,
    output logic reg4_power_good,
    output logic slow_clock_output,
    output logic internalOscSelected,
    output logic goSleepOrReboot,
    output logic [7:0] appliedVolt [NUM_RAILS]
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    srs_pins_type pinsMeta_reg; // First stage, read only by second
    srs_pins_type pins_reg; // Synchronised pins
    srs_pins_type pinsPrev_reg; // Previous for edge detect
    srs_phase_type phasePrev_reg; // Previous phase

    // Two-flop synchroniser for pins
    always_ff @(posedge clk) begin
        if (rst) begin
            pinsMeta_reg <= '{1'b1, 1'b0, 1'b0, 1'b0};
            pins_reg <= '{1'b1, 1'b0, 1'b0, 1'b0};
            pinsPrev_reg <= '{1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            pinsMeta_reg <= '{stepdown_a_enable_pin, stepdown_b_enable_pin,
                              sync_group_enable_pin, reg4_enable_pin};
            pins_reg <= pinsMeta_reg;
            pinsPrev_reg <= pins_reg;
        end
    end

    // Phase history for entry detection
    always_ff @(posedge clk) begin
        if (rst) begin
            phasePrev_reg <= PH_OFF;
        end else begin
            phasePrev_reg <= phase;
        end
    end

    // ==========================================================
    // Phase decode and group triggers
    // ==========================================================
    logic inSeq, inNormal, inReq, enterReq, enterDown, enterSeq;
    logic [3:0] grpLevel; // Group active level, by trigger code
    logic [3:0] grpAssert; // Asserting edge this cycle
    logic [3:0] grpDeassert; // Deasserting edge this cycle

    assign inSeq = (phase == PH_SEQ);
    assign inNormal = (phase == PH_NORMAL);
    assign inReq = (phase == PH_SLEEP_REQ) || (phase == PH_REBOOT_REQ);
    assign enterReq = inReq && (phasePrev_reg != PH_SLEEP_REQ)
                      && (phasePrev_reg != PH_REBOOT_REQ); // [RL16]
    assign enterDown = ((phase == PH_SLEEP) || (phase == PH_REBOOT))
                       && (phasePrev_reg != PH_SLEEP)
                       && (phasePrev_reg != PH_REBOOT);
    assign enterSeq = inSeq && (phasePrev_reg == PH_RTC); // [RL4]

    // Group levels: A active low, others active high
    always_comb begin
        grpLevel[TRIG_INTERNAL] = inSeq; // [RL4]
        grpLevel[TRIG_SDA] = !pins_reg.sdaEnableN; // [RL5]
        grpLevel[TRIG_SDB] = pins_reg.sdbEnable; // [RL6]
        grpLevel[TRIG_SYNC] = pins_reg.syncEnable; // [RL6]
        grpAssert[TRIG_INTERNAL] = enterSeq;
        grpAssert[TRIG_SDA] = pinsPrev_reg.sdaEnableN
                              && !pins_reg.sdaEnableN; // [RL5]
        grpAssert[TRIG_SDB] = !pinsPrev_reg.sdbEnable
                              && pins_reg.sdbEnable; // [RL6]
        grpAssert[TRIG_SYNC] = !pinsPrev_reg.syncEnable
                               && pins_reg.syncEnable; // [RL6]
        grpDeassert[TRIG_INTERNAL] = 1'b0; // [RL18]
        grpDeassert[TRIG_SDA] = !pinsPrev_reg.sdaEnableN
                                && pins_reg.sdaEnableN; // [RL19]
        grpDeassert[TRIG_SDB] = pinsPrev_reg.sdbEnable
                                && !pins_reg.sdbEnable; // [RL19]
        grpDeassert[TRIG_SYNC] = pinsPrev_reg.syncEnable
                                 && !pins_reg.syncEnable; // [RL19]
    end

    // ==========================================================
    // Per-rail delay timers and enables
    // ==========================================================
    logic [CNT_W-1:0] railCnt_reg [NUM_RAILS]; // Delay counters
    logic [NUM_RAILS-1:0] railArmed_reg; // Timer running
    logic [NUM_RAILS-1:0] seqOn_reg; // Sequenced on
    logic [NUM_RAILS-1:0] pinOff_reg; // Turned off by pin in request
    logic [NUM_RAILS-1:0] pinCtrl; // Pin switches rail now
    logic [NUM_RAILS-1:0] railOn_next;
    logic reg4Hold_reg; // Rail 4 kept on until shutdown

    // Timers: start on asserting edge during sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            railArmed_reg <= '0;
            seqOn_reg <= '0;
            for (int r = 0; r < NUM_RAILS; r++) begin
                railCnt_reg[r] <= '0;
            end
        end else begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                if (!inSeq && !inNormal && !inReq) begin
                    // Outside sequencing, normal and request, armed and on flags cleared
                    railArmed_reg[r] <= 1'b0;
                    seqOn_reg[r] <= 1'b0;
                end else if (inSeq && railCfg(r).defaultOn
                             && grpAssert[railCfg(r).trig]) begin
                    // Reload on every recurring trigger [RL7] [RL27]
                    // Delay sharing [RL10] [RL11] [RL12]
                    railCnt_reg[r] <= dlyCycles(railCfg(r).dly); // [RL3]
                    railArmed_reg[r] <= 1'b1;
                end else if (railArmed_reg[r] && !inSeq) begin
                    // No delays after normal entry [RL9]
                    railArmed_reg[r] <= 1'b0;
                end else if (railArmed_reg[r]) begin
                    if (railCnt_reg[r] == '0) begin
                        railArmed_reg[r] <= 1'b0;
                        seqOn_reg[r] <= grpLevel[railCfg(r).trig]; // [RL7]
                    end else begin
                        railCnt_reg[r] <= railCnt_reg[r] - 1'b1;
                    end
                end
            end
        end
    end

    // Which rails the pins may switch in the current phase
    always_comb begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            if (inNormal) begin
                pinCtrl[r] = (r == RAIL_SDA) || (r == RAIL_SDB)
                             || (r == RAIL_REG4); // [RL14]
            end else begin
                pinCtrl[r] = (railCfg(r).trig != TRIG_INTERNAL); // [RL13]
            end
        end
    end

    // Request-phase pin turn-off, sticky until shutdown
    always_ff @(posedge clk) begin
        if (rst || !inReq) begin
            pinOff_reg <= '0;
        end else begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                if (grpDeassert[railCfg(r).trig] || ((r == RAIL_REG4)
                    && pinsPrev_reg.reg4Enable && !pins_reg.reg4Enable)) begin
                    pinOff_reg[r] <= 1'b1; // [RL19]
                end
            end
        end
    end

    // Rail 4 held on when its pin is low at request entry
    always_ff @(posedge clk) begin
        if (rst || enterDown || !(inReq)) begin
            reg4Hold_reg <= 1'b0;
        end else if (enterReq && !pins_reg.reg4Enable && railOn[RAIL_REG4]) begin
            reg4Hold_reg <= 1'b1; // [RL20]
        end
    end

    // Rail enable combine
    always_comb begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            railOn_next[r] = railOn[r];
            if (inSeq) begin
                // Sequenced start, default-off rails excluded [RL8] [RL1]
                railOn_next[r] = seqOn_reg[r] && railCfg(r).defaultOn;
                if ((r == RAIL_REG2) || (r == RAIL_REG4) || (r == RAIL_SDA)
                    || (r == RAIL_SDB)) begin
                    railOn_next[r] = railOn_next[r]
                                     || railEnableBits[r]; // [RL15]
                end
            end else if (inNormal) begin
                // Bits switch all; some pins too, without delay [RL9]
                railOn_next[r] = railEnableBits[r]; // [RL14]
                if (pinCtrl[r]) begin
                    if (r == RAIL_REG4) begin
                        railOn_next[r] = railOn_next[r]
                                         || pins_reg.reg4Enable;
                    end else begin
                        railOn_next[r] = railOn_next[r]
                                         || grpLevel[railCfg(r).trig];
                    end
                end
            end else if (inReq) begin
                // Pins act again; deasserting edge turns off [RL16]
                railOn_next[r] = railOn[r] && !pinOff_reg[r];
                if (r == RAIL_REG4 && reg4Hold_reg) begin
                    railOn_next[r] = 1'b1; // [RL20]
                end
            end else begin
                railOn_next[r] = 1'b0; // [RL18]
            end
        end
    end

    // Rail enable register; shutdown drops all at once
    always_ff @(posedge clk) begin
        if (rst || enterDown) begin
            railOn <= '0; // [RL18]
        end else begin
            railOn <= railOn_next;
        end
    end

    // Always-on regulator from RTC state onward
    always_ff @(posedge clk) begin
        if (rst) begin
            rtcRegOn <= 1'b0;
        end else if (phase != PH_OFF) begin
            rtcRegOn <= 1'b1; // [RL2]
        end else begin
            rtcRegOn <= 1'b0;
        end
    end

    // ==========================================================
    // Request wait timer
    // ==========================================================
    logic [CNT_W-1:0] waitCnt_reg; // Counts the request wait

    // Reloaded at each request entry, pulse on expiry
    always_ff @(posedge clk) begin
        if (rst) begin
            waitCnt_reg <= '0;
            goSleepOrReboot <= 1'b0;
        end else begin
            goSleepOrReboot <= 1'b0;
            if (enterReq) begin
                waitCnt_reg <= CNT_W'(WAIT_REQ_CYC - 1); // [RL17] [RL27]
            end else if (inReq && waitCnt_reg != '0) begin
                waitCnt_reg <= waitCnt_reg - 1'b1;
                goSleepOrReboot <= (waitCnt_reg == CNT_W'(1)); // [RL17]
            end
        end
    end

    // ==========================================================
    // Power-good outputs
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            stepdown_a_power_good <= 1'b0;
            stepdown_b_power_good <= 1'b0;
            reg4_power_good <= 1'b0;
        end else begin
            stepdown_a_power_good <= railOn[RAIL_SDA]
                                     && railInRegulation[RAIL_SDA]; // [RL22]
            stepdown_b_power_good <= railOn[RAIL_SDB]
                                     && railInRegulation[RAIL_SDB]; // [RL22]
            reg4_power_good <= railOn[RAIL_REG4] && pins_reg.reg4Enable
                               && railInRegulation[RAIL_REG4]; // [RL21]
        end
    end

    // ==========================================================
    // Slow clock output gating
    // ==========================================================
    logic [1:0] rtcMeta_reg, vMeta_reg; // Level synchronisers

    always_ff @(posedge clk) begin
        if (rst) begin
            rtcMeta_reg <= 2'h0;
            vMeta_reg <= 2'h0;
            slow_clock_output <= 1'b0;
            internalOscSelected <= 1'b0;
        end else begin
            rtcMeta_reg <= {rtcMeta_reg[0], rtc_reset_output};
            vMeta_reg <= {vMeta_reg[0], slow_clock_domain_supply};
            internalOscSelected <= !slowSourceXtal; // [RL24]
            // Only crystal clock reaches the pin [RL24] [RL23]
            slow_clock_output <= rtcMeta_reg[1] && vMeta_reg[1]
                                 && xtalClockEnable;
        end
    end

    // ==========================================================
    // Output voltage codes
    // ==========================================================
    logic [7:0] rampTarget_reg [NUM_RAILS]; // Scaling final codes

    // Non-scaling at acknowledge; scaling steps from start
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                appliedVolt[r] <= 8'h00;
                rampTarget_reg[r] <= 8'h00;
            end
        end else begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                if (voltWriteAck[r] && !scalingRail[r]) begin
                    appliedVolt[r] <= voltCode; // [RL25]
                end else if (voltWriteAck[r]) begin
                    rampTarget_reg[r] <= voltCode;
                end else if (scalingRail[r] && scalingStart
                             && appliedVolt[r] != rampTarget_reg[r]) begin
                    // One code step per start strobe [RL26]
                    if (appliedVolt[r] < rampTarget_reg[r]) begin
                        appliedVolt[r] <= appliedVolt[r] + 8'h01;
                    end else begin
                        appliedVolt[r] <= appliedVolt[r] - 8'h01;
                    end
                end
            end
        end
    end

endmodule : srs_supply_rail_sequencer

`default_nettype wire

// *** testbench/srs_host_model.sv ***
// Host model driving the trigger pins of the sequencer
`timescale 1ns/1ps
`default_nettype none
module srs_host_model
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin levels asked for
    input wire srs_pins_type want,
    // Trigger pins to the sequencer
    output wire srs_pins_type pins
);
    // ==========
    // Pin drive, idle with stepdown A pin high
    srs_pins_type drv = 4'h8;
    assign pins = drv;
    // Launches each level just after the edge
    always @(posedge clk) begin
        if (rst) drv <= 4'h8;
        else drv <= want;
    end
endmodule : srs_host_model
`default_nettype wire

// *** testbench/srs_seq_chk.sv ***
// Port checker of the supply rail sequencer
`timescale 1ns/1ps
`default_nettype none
module srs_chk
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched inputs
    input wire srs_phase_type phase,
    input wire logic reg4_enable_pin,
    input wire logic [NUM_RAILS-1:0] railEnableBits,
    input wire logic slowSourceXtal,
    input wire logic rtc_reset_output,
    // Watched outputs and the rail regulation status input
    input wire logic [NUM_RAILS-1:0] railOn,
    input wire logic [NUM_RAILS-1:0] railInRegulation,
    input wire logic rtcRegOn,
    input wire logic stepdown_a_power_good,
    input wire logic reg4_power_good,
    input wire logic slow_clock_output,
    input wire logic internalOscSelected,
    input wire logic goSleepOrReboot
);
    // ==========
    // Default-off rails, and rails no pin reaches in normal
    localparam logic [12:0] OFF_MASK = 13'h1389;
    localparam logic [12:0] NOPIN_MASK = 13'h13EF;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Two samples in one phase
    sequence s_held(srs_phase_type p);
        phase == p ##1 phase == p;
    endsequence
    // Two samples in a powered-down phase
    sequence s_down;
        phase inside {PH_SLEEP, PH_REBOOT} ##1 phase inside {PH_SLEEP, PH_REBOOT};
    endsequence
    property p_seq_off;
        s_held(PH_SEQ) |-> (railOn & OFF_MASK) == 13'h0000;
    endproperty
    a_seq_off: assert property (p_seq_off) else $error("off rail on");
    property p_down;
        s_down |-> railOn == 13'h0000;
    endproperty
    a_down: assert property (p_down) else $error("rail on asleep");
    property p_rtc;
        phase == PH_RTC |-> ##[0:2] rtcRegOn;
    endproperty
    a_rtc: assert property (p_rtc) else $error("rtc reg off");
    property p_norm;
        (phase == PH_NORMAL && $stable(railEnableBits))[*3]
            |-> (railOn & NOPIN_MASK) == (railEnableBits & NOPIN_MASK);
    endproperty
    a_norm: assert property (p_norm) else $error("normal rail");
    property p_r4pg;
        (!reg4_enable_pin)[*4] |-> !reg4_power_good;
    endproperty
    a_r4pg: assert property (p_r4pg) else $error("reg4 good");
    property p_pg;
        (!(railOn[RAIL_SDA] && railInRegulation[RAIL_SDA]))[*3]
            |-> !stepdown_a_power_good;
    endproperty
    a_pg: assert property (p_pg) else $error("sda good");
    property p_osc;
        $stable(slowSourceXtal)[*3] |-> internalOscSelected == !slowSourceXtal;
    endproperty
    a_osc: assert property (p_osc) else $error("source sel");
    property p_clk;
        (!rtc_reset_output)[*4] |-> !slow_clock_output;
    endproperty
    a_clk: assert property (p_clk) else $error("slow clock");
    property p_go;
        goSleepOrReboot |-> $past(phase) inside {PH_SLEEP_REQ, PH_REBOOT_REQ}
            ##1 !goSleepOrReboot;
    endproperty
    a_go: assert property (p_go) else $error("go pulse");
endmodule : srs_chk
bind srs_supply_rail_sequencer srs_chk u_chk (.clk(clk), .rst(rst),
    .phase(phase), .reg4_enable_pin(reg4_enable_pin),
    .railEnableBits(railEnableBits), .slowSourceXtal(slowSourceXtal),
    .rtc_reset_output(rtc_reset_output), .railOn(railOn),
    .railInRegulation(railInRegulation), .rtcRegOn(rtcRegOn),
    .stepdown_a_power_good(stepdown_a_power_good),
    .reg4_power_good(reg4_power_good), .slow_clock_output(slow_clock_output),
    .internalOscSelected(internalOscSelected),
    .goSleepOrReboot(goSleepOrReboot));
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking testbench of the supply rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import srs_pkg::*;
();
    // ==========
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    srs_phase_type phase = PH_OFF;
    srs_pins_type want = 4'h8;
    srs_pins_type pins;
    logic [12:0] bits = '0;
    logic [12:0] inReg = '0;
    logic [12:0] ack = '0;
    logic [7:0] code = '0;
    logic xtal = 1'b0, rtcRst = 1'b0;
    logic [12:0] railOn;
    logic rtcRegOn, sdaPg, sdbPg, r4Pg, slowClk, intOsc, goDown;
    logic [7:0] appliedVolt [NUM_RAILS];
    logic [14:0] noteQ [$];
    int num_errors = 0;
    int samples_checked = 0;
    integer seed = 32'h0000_8225;
    // Clock at 4 ns
    initial forever #2 clk = ~clk;
    // Host on the trigger pins
    srs_host_model host (.clk(clk), .rst(rst), .want(want), .pins(pins));
    srs_supply_rail_sequencer dut (.clk(clk), .rst(rst), .phase(phase),
        .stepdown_a_enable_pin(pins.sdaEnableN),
        .stepdown_b_enable_pin(pins.sdbEnable),
        .sync_group_enable_pin(pins.syncEnable),
        .reg4_enable_pin(pins.reg4Enable), .railEnableBits(bits),
        .railInRegulation(inReg), .voltCode(code), .voltWriteAck(ack),
        .scalingRail(13'h0C14), .scalingStart(1'b0), .slowSourceXtal(xtal),
        .xtalClockEnable(1'b1), .rtc_reset_output(rtcRst),
        .slow_clock_domain_supply(1'b1), .railOn(railOn),
        .rtcRegOn(rtcRegOn), .stepdown_a_power_good(sdaPg),
        .stepdown_b_power_good(sdbPg), .reg4_power_good(r4Pg),
        .slow_clock_output(slowClk), .internalOscSelected(intOsc),
        .goSleepOrReboot(goDown), .appliedVolt(appliedVolt));
    // Compare of one value
    task automatic check(input string nm, input logic [14:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // Note of reg4 good, stepdown A good and rails
    task automatic note(input logic [12:0] r, input logic a, input logic f);
        noteQ.push_back({f, a, r});
        step(1);
    endtask : note
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Monitor: takes pending notes at the falling edge
    always @(negedge clk) begin
        while (noteQ.size() > 0) check("rails", {r4Pg, sdaPg, railOn}, noteQ.pop_front());
    end
    // Watchdog on the whole run
    initial begin
        step(60000);
        num_errors++;
        test_done();
    end
    // Main sequence
    initial begin
        logic [12:0] e;
        step(8);
        rst <= 1'b0;
        step(1);
        note('0, 1'b0, 1'b0);
        phase <= PH_RTC;
        step(4);
        check("rtc", 15'(rtcRegOn), 15'h0001);
        $display("test rtc done");
        // Sequencing with pins asserted: only zero-delay rail 2
        phase <= PH_SEQ;
        want <= 4'h6;
        step(40);
        note(13'h0004, 1'b0, 1'b0);
        $display("test seq done");
        // Normal: random bits, pins and voltage writes, no delays
        phase <= PH_NORMAL;
        for (int i = 0; i < 8; i++) begin
            bits <= 13'($random(seed));
            inReg <= 13'($random(seed));
            want <= 4'($random(seed));
            xtal <= 1'($random(seed));
            rtcRst <= 1'($random(seed));
            code <= 8'($random(seed));
            ack <= 13'h0001;
            step(1);
            ack <= '0;
            step(6);
            e = bits;
            e[RAIL_SDA] = e[RAIL_SDA] | !want.sdaEnableN;
            e[RAIL_SDB] = e[RAIL_SDB] | want.sdbEnable;
            e[RAIL_REG4] = e[RAIL_REG4] | want.reg4Enable;
            note(e, e[10] & inReg[10], e[4] & inReg[4] & want.reg4Enable);
            check("volt", 15'(appliedVolt[RAIL_REG0]), 15'(code));
            check("osc", 15'(intOsc), 15'(!xtal));
            check("clk", 15'(slowClk), 15'(rtcRst));
            check("sdbpg", 15'(sdbPg), 15'(e[11] & inReg[11]));
        end
        $display("test normal done");
        // Sleep request: deasserting pin edges switch rails off
        bits <= 13'h0081;
        want <= 4'hD;
        inReg <= 13'h1FFF;
        step(8);
        phase <= PH_SLEEP_REQ;
        step(8);
        note(13'h0891, 1'b0, 1'b1);
        want <= 4'h8;
        step(8);
        note(13'h0080, 1'b0, 1'b0);
        phase <= PH_SLEEP;
        step(3);
        note('0, 1'b0, 1'b0);
        $display("test sleep done");
        // Reboot request with reg4 pin already low
        phase <= PH_NORMAL;
        bits <= 13'h0010;
        step(8);
        phase <= PH_REBOOT_REQ;
        bits <= '0;
        step(20);
        note(13'h0010, 1'b0, 1'b0);
        phase <= PH_REBOOT;
        step(3);
        note('0, 1'b0, 1'b0);
        $display("test reboot done");
        step(2);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
